// ===== rtl/dip_pipeline_ctrl.sv
`timescale 1ns/100ps
`include "dip_params.svh"
module dip_pipeline_ctrl
  import dip_pkg::*;
#(
  parameter bit FAST_IO = 1'b1,
  parameter int STORE_DEPTH = `DIP_STORE_DEPTH
)(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [1:0] slotValid,
  input wire dip_class_type [1:0] slotClass,
  input wire logic [1:0][4:0] slotRd,
  input wire logic [1:0][4:0] slotRs1,
  input wire logic [1:0][4:0] slotRs2,
  input wire logic [1:0] slotAddrRs1,
  input wire logic [1:0] slotCsrFlush,
  output logic [1:0] issue,
  input wire logic [63:0] memAddr,
  input wire logic [63:0] memBase,
  input wire dip_size_type memSize,
  input wire logic [63:0] memData,
  input wire logic [6:0] divLogDividend,
  input wire logic [6:0] divLogDivisor,
  input wire logic divNegIn,
  input wire logic divNegOut,
  output logic divDone,
  output logic flush,
  output logic trapMisaligned,
  output logic trapAccess,
  output logic tdmReq,
  output logic tdmWrite,
  output logic [`DIP_TDM_ADDR_BITS-1:0] tdmAddr,
  output logic [63:0] tdmWdata,
  output logic loadDone,
  input wire logic ioReady,
  output logic ioReq,
  output logic ioWrite,
  output logic [63:0] ioAddr,
  input wire logic ioRespValid,
  output logic ioLoadDone,
  input wire logic fetchValid,
  input wire logic [63:0] fetchAddr,
  output logic icacheFill,
  output logic [1:0] retireCount,
  output logic [`DIP_STAGE_COUNT-1:0] stageBusy
);
  localparam int AW = `DIP_TDM_ADDR_BITS;
  // ================================================================
  // elaboration checks
  initial
  begin
    if ((1 << AW) != `DIP_TDM_BYTES)
      $error("tight memory window does not match its size");
    if (STORE_DEPTH < 1)
      $error("store pipeline needs at least one entry");
  end
  // ================================================================
  // helpers
  function automatic logic inTdm(input logic [63:0] a);
    inTdm = (a[63:AW] == `DIP_TDM_BASE >> AW);
  endfunction : inTdm
  function automatic logic misaligned(input logic [63:0] a,
                                      input dip_size_type s);
    misaligned = ((a[2:0] & (3'((4'h1 << s) - 4'h1))) != 3'h0);
  endfunction : misaligned
  function automatic logic isMem(input dip_class_type c);
    isMem = (c == DIP_LOAD) || (c == DIP_STORE) || (c == DIP_LRSC);
  endfunction : isMem
  function automatic logic isMulDiv(input dip_class_type c);
    isMulDiv = (c == DIP_MUL) || (c == DIP_DIV);
  endfunction : isMulDiv
  function automatic logic isCtl(input dip_class_type c);
    isCtl = (c == DIP_BRANCH) || (c == DIP_JUMP);
  endfunction : isCtl
  function automatic logic isCsr(input dip_class_type c);
    isCsr = (c == DIP_CSR_READ) || (c == DIP_CSR_WRITE);
  endfunction : isCsr
  // operand needed at agen entry (early) or may arrive by mem2
  function automatic logic srcOk(input logic [6:0] t, input logic early);
    srcOk = early ? (t == 7'h00) : (t <= `DIP_LATE_SLACK);
  endfunction : srcOk
  // divide latency, held inside its documented range
  function automatic logic [6:0] divLat(input logic [6:0] ld,
                                        input logic [6:0] ls,
                                        input logic ni, input logic no);
    logic [7:0] raw;
    raw = 8'(`DIP_DIV_BASE) + ((ld > ls) ? 8'(ld - ls) : 8'h00)
          + 8'(ni) + 8'(no);
    if (raw < 8'(`DIP_DIV_MIN))
      raw = 8'(`DIP_DIV_MIN);
    if (raw > 8'(`DIP_DIV_MAX))
      raw = 8'(`DIP_DIV_MAX);
    divLat = 7'(raw);
  endfunction : divLat
  // ================================================================
  // all registered state of the controller
  typedef struct packed {
    dip_mode_type mode;          // run, flush or penalty
    logic [6:0] waitCount;       // cycles left in flush or penalty
    logic [31:0][6:0] ready;     // per register cycles to bypass
    logic divBusy;               // iterative divider running
    logic [6:0] divCount;        // cycles left in divide
    logic [4:0] divRd;           // divide destination
    logic divDone;               // divide result pulse
    logic [2:0] loadPipe;        // tight load completion shifter
    logic replay;                // io prediction was wrong
    logic ioGap;                 // half rate lockout without fast io
    logic ioReq;
    logic ioWrite;
    logic [63:0] ioAddr;
    logic ioLoadDone;
    logic tdmReq;
    logic tdmWrite;
    logic [AW-1:0] tdmAddr;
    logic [63:0] tdmWdata;
    logic trapMis;
    logic trapAcc;
    logic flush;
    logic icacheFill;
    logic [5:0][1:0] stageCnt;   // occupancy d1,d2,ag,m1,m2,wb
  } dip_state_type;
  dip_state_type state;
  dip_state_type next_state;
  // ================================================================
  // store pipeline toward the tight memory
  logic sqPush;
  logic sqReady;
  logic sqIdle;
  logic sqCommit;
  logic [AW-1:0] sqCommitAddr;
  logic [63:0] sqCommitData;
  logic sqHit;
  dip_store_queue #(
    .DEPTH(STORE_DEPTH),
    .AW(AW)
  ) storeQueue (
    .core_clk(core_clk),
    .rst(rst),
    .pushValid(sqPush),
    .pushReady(sqReady),
    .pushAddr(memAddr[AW-1:0]),
    .pushData(memData),
    .memIdle(sqIdle),
    .commitValid(sqCommit),
    .commitAddr(sqCommitAddr),
    .commitData(sqCommitData),
    .probeAddr(memAddr[AW-1:0]),
    .probeHit(sqHit)
  );
  // ================================================================
  // per-slot hazard and resource decisions
  logic [1:0] hazard;            // raw or waw on the scoreboard
  logic [1:0][6:0] slotLat;      // timer load of each slot's result
  logic memSlot;                 // which slot holds the memory op
  logic memPresent;              // a memory op is offered
  logic memIsTdm;                // actual target is the tight memory
  logic memPredIo;               // base register predicts io
  logic memTrapMis;
  logic memTrapAcc;
  logic memStall;                // memory op cannot go this cycle
  logic memPenalty;              // load meets a pending store
  logic pairOk;
  always_comb
  begin
    for (int s = 0; s < 2; s++)
    begin
      logic e1;
      logic e2;
      logic late;
      e1 = slotAddrRs1[s] || isMulDiv(slotClass[s]);
      e2 = isMulDiv(slotClass[s]);
      late = (state.ready[slotRs1[s]] != 7'h00)
             || (state.ready[slotRs2[s]] != 7'h00);
      unique case (slotClass[s])
        DIP_ALU: slotLat[s] = (late ? `DIP_LAT_ALU_LATE
                              : `DIP_LAT_ALU_EARLY) - 7'd1;
        DIP_LOAD: slotLat[s] = `DIP_LAT_LOAD - 7'd1;
        DIP_MUL: slotLat[s] = `DIP_LAT_MUL - 7'd1;
        DIP_CSR_READ: slotLat[s] = `DIP_LAT_CSR_READ - 7'd1;
        DIP_DIV: slotLat[s] = `DIP_TIMER_DIV_PENDING;
        default: slotLat[s] = 7'h00;
      endcase
      // only read-after-write and write-after-write stall issue
      hazard[s] = !srcOk(state.ready[slotRs1[s]], e1)
                  || !srcOk(state.ready[slotRs2[s]], e2)
                  || (slotRd[s] != 5'h00
                      && state.ready[slotRd[s]] > slotLat[s]);
    end
    memSlot = !isMem(slotClass[0]);
    memPresent = slotValid[memSlot] && isMem(slotClass[memSlot]);
    memIsTdm = inTdm(memAddr);
    memPredIo = !inTdm(memBase) && !state.replay;
    memTrapMis = misaligned(memAddr, memSize);
    memTrapAcc = (slotClass[memSlot] == DIP_LRSC);
    memPenalty = memPresent && memIsTdm && !memTrapMis && !memTrapAcc
                 && (slotClass[memSlot] == DIP_LOAD) && sqHit;
    memStall = 1'b0;
    if (memPresent && !memTrapMis && !memTrapAcc)
    begin
      if (memPredIo == memIsTdm)
        memStall = 1'b1; // a wrong io guess costs one replay cycle; a wrong tight guess keeps stalling
      else if (memIsTdm)
        memStall = memPenalty
                   || (slotClass[memSlot] == DIP_STORE && !sqReady);
      else
        memStall = !ioReady
                   || (state.ioGap && slotClass[memSlot] == DIP_LOAD);
    end
    // dual-issue resource limits
    pairOk = !(isMem(slotClass[0]) && isMem(slotClass[1]))
             && !(isCtl(slotClass[0]) && isCtl(slotClass[1]))
             && !(isMulDiv(slotClass[0]) && isMulDiv(slotClass[1]))
             && !isCsr(slotClass[0]) && !isCsr(slotClass[1])
             && !(slotRd[0] != 5'h00
                  && (slotRs1[1] == slotRd[0] || slotRs2[1] == slotRd[0]
                      || slotRd[1] == slotRd[0]));
  end
  // ================================================================
  // issue decision: slot one only travels with slot zero
  always_comb
  begin
    issue = 2'b00;
    if (state.mode == DIP_RUN && slotValid[0] && !hazard[0]
        && !(slotClass[0] == DIP_DIV && state.divBusy)
        && !(memSlot == 1'b0 && memStall))
    begin
      issue[0] = 1'b1;
      if (slotValid[1] && !hazard[1] && pairOk
          && !(slotClass[1] == DIP_DIV && state.divBusy)
          && !(memSlot == 1'b1 && memStall)
          && !(memSlot == 1'b0 && (memTrapMis || memTrapAcc)))
        issue[1] = 1'b1;
    end
  end
  // ================================================================
  // memory routing for the issuing memory op
  logic memGo;
  logic tdmLoadGo;
  always_comb
  begin
    memGo = memPresent && issue[memSlot] && !memTrapMis && !memTrapAcc;
    tdmLoadGo = memGo && memIsTdm && slotClass[memSlot] == DIP_LOAD;
    sqPush = memGo && memIsTdm && slotClass[memSlot] == DIP_STORE;
    sqIdle = !tdmLoadGo; // stores use only idle cycles
  end
  // ================================================================
  // next-state logic
  always_comb
  begin
    next_state = state;
    next_state.flush = 1'b0;
    next_state.trapMis = 1'b0;
    next_state.trapAcc = 1'b0;
    next_state.divDone = 1'b0;
    next_state.tdmReq = 1'b0;
    next_state.ioReq = 1'b0;
    next_state.replay = 1'b0;
    next_state.ioGap = 1'b0;
    // scoreboard countdown; divide entry waits for the divider
    for (int r = 1; r < 32; r++)
      if (state.ready[r] != 7'h00
          && state.ready[r] != `DIP_TIMER_DIV_PENDING)
        next_state.ready[r] = state.ready[r] - 7'd1;
    // iterative divider
    if (state.divBusy)
    begin
      if (state.divCount == 7'h00)
      begin
        next_state.divBusy = 1'b0;
        next_state.divDone = 1'b1;
        if (state.ready[state.divRd] == `DIP_TIMER_DIV_PENDING)
          next_state.ready[state.divRd] = 7'h00;
      end
      else
        next_state.divCount = state.divCount - 7'd1;
    end
    // scoreboard entries for issued instructions
    for (int s = 0; s < 2; s++)
      if (issue[s])
      begin
        if (slotRd[s] != 5'h00 && slotClass[s] != DIP_STORE
            && !isCtl(slotClass[s]) && slotClass[s] != DIP_LRSC)
          next_state.ready[slotRd[s]] = slotLat[s];
        if (slotClass[s] == DIP_DIV)
        begin
          next_state.divBusy = 1'b1;
          next_state.divRd = slotRd[s];
          // done pulse and freed result land on the latency's own cycle
          next_state.divCount = divLat(divLogDividend, divLogDivisor,
                                       divNegIn, divNegOut) - 7'd2;
        end
      end
    // occupancy walks d1 to d2 and ag to wb one stage per cycle; ag loads the issue count
    next_state.stageCnt[0] = 2'(slotValid[0]) + 2'(slotValid[1]);
    next_state.stageCnt[1] = state.stageCnt[0];
    next_state.stageCnt[2] = 2'(issue[0]) + 2'(issue[1]);
    for (int k = 3; k < 6; k++)
      next_state.stageCnt[k] = state.stageCnt[k-1];
    // tight load completion, two cycles wide, three narrow
    next_state.loadPipe = {1'b0, state.loadPipe[2:1]};
    if (tdmLoadGo)
    begin
      if (memSize >= 2'd2)
        next_state.loadPipe[`DIP_TDM_LAT_WIDE-1] = 1'b1;
      else
        next_state.loadPipe[`DIP_TDM_LAT_NARROW-1] = 1'b1;
      next_state.tdmReq = 1'b1;
      next_state.tdmWrite = 1'b0;
      next_state.tdmAddr = memAddr[AW-1:0];
    end
    else if (sqCommit)
    begin
      next_state.tdmReq = 1'b1;
      next_state.tdmWrite = 1'b1;
      next_state.tdmAddr = sqCommitAddr;
      next_state.tdmWdata = sqCommitData;
    end
    // mapped io, all accesses non-cacheable
    if (memGo && !memIsTdm)
    begin
      next_state.ioReq = 1'b1;
      next_state.ioWrite = (slotClass[memSlot] == DIP_STORE);
      next_state.ioAddr = memAddr;
      next_state.ioGap = !FAST_IO && slotClass[memSlot] == DIP_LOAD;
    end
    // wrong prediction: retry next cycle predicting the tight memory
    if (memPresent && state.mode == DIP_RUN && !state.replay
        && memPredIo == memIsTdm && !memTrapMis && !memTrapAcc)
      next_state.replay = 1'b1;
    // response path independent of requests
    next_state.ioLoadDone = ioRespValid;
    // instruction fetch out of tight memory goes via icache
    next_state.icacheFill = fetchValid && inTdm(fetchAddr);
    // mode sequencing
    unique case (state.mode)
      DIP_RUN:
      begin
        if (memPresent && issue[memSlot] && (memTrapMis || memTrapAcc))
        begin
          next_state.trapMis = memTrapMis;
          next_state.trapAcc = !memTrapMis && memTrapAcc;
          next_state.flush = 1'b1;
          next_state.mode = DIP_FLUSH;
          next_state.waitCount = `DIP_CSR_FLUSH_CYCLES - 7'd2;
        end
        else if (issue[0] && slotClass[0] == DIP_CSR_WRITE
                 && slotCsrFlush[0])
        begin
          next_state.flush = 1'b1;
          next_state.mode = DIP_FLUSH;
          next_state.waitCount = `DIP_CSR_FLUSH_CYCLES - 7'd2;
        end
        else if (state.mode == DIP_RUN && !issue[0] && memPenalty
                 && memSlot == 1'b0)
        begin
          next_state.mode = DIP_PENALTY;
          next_state.waitCount = `DIP_STORE_HIT_CYCLES - 7'd2;
        end
      end
      DIP_FLUSH, DIP_PENALTY:
      begin
        if (state.waitCount == 7'h00)
          next_state.mode = DIP_RUN;
        else
          next_state.waitCount = state.waitCount - 7'd1;
      end
      default:
        next_state.mode = DIP_RUN;
    endcase
    // a flush empties only the two decode stages, d1 and d2
    if (state.flush)
    begin
      next_state.stageCnt[0] = 2'h0;
      next_state.stageCnt[1] = 2'h0;
    end
  end
  // ================================================================
  // state register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= '0;
      state.mode <= DIP_RUN;
    end
    else
      state <= next_state;
  end
  // ================================================================
  // outputs from the state register, except the combinational issue and stageBusy bit zero taken from fetchValid
  assign divDone = state.divDone;
  assign flush = state.flush;
  assign trapMisaligned = state.trapMis;
  assign trapAccess = state.trapAcc;
  assign tdmReq = state.tdmReq;
  assign tdmWrite = state.tdmWrite;
  assign tdmAddr = state.tdmAddr;
  assign tdmWdata = state.tdmWdata;
  assign loadDone = state.loadPipe[0];
  assign ioReq = state.ioReq;
  assign ioWrite = state.ioWrite;
  assign ioAddr = state.ioAddr;
  assign ioLoadDone = state.ioLoadDone;
  assign icacheFill = state.icacheFill;
  assign retireCount = state.stageCnt[5];
  // fetch stages follow the fetch request, later stages occupancy
  assign stageBusy = {state.stageCnt[5] != 2'h0,
                      state.stageCnt[4] != 2'h0,
                      state.stageCnt[3] != 2'h0,
                      state.stageCnt[2] != 2'h0,
                      state.stageCnt[1] != 2'h0,
                      state.stageCnt[0] != 2'h0,
                      state.icacheFill, fetchValid};
endmodule : dip_pipeline_ctrl

// ===== rtl/dip_params.svh
`ifndef DIP_PARAMS_SVH
`define DIP_PARAMS_SVH
// ==================================================================
// pipeline shape
`define DIP_STAGE_COUNT 8
`define DIP_ISSUE_WIDTH 2
// ==================================================================
// result latencies in cycles (timer loads are latency minus one)
`define DIP_LAT_ALU_EARLY 7'd1
`define DIP_LAT_ALU_LATE 7'd3
`define DIP_LAT_LOAD 7'd3
`define DIP_LAT_MUL 7'd3
`define DIP_LAT_CSR_READ 7'd1
`define DIP_LATE_SLACK 7'd2
`define DIP_TIMER_DIV_PENDING 7'h7F
`define DIP_DIV_BASE 7'd2
`define DIP_DIV_MIN 7'd6
`define DIP_DIV_MAX 7'd68
// ==================================================================
// penalties in cycles
`define DIP_CSR_FLUSH_CYCLES 7'd7
`define DIP_STORE_HIT_CYCLES 7'd5
// ==================================================================
// tight data memory
`define DIP_TDM_BYTES 8192
`define DIP_TDM_ADDR_BITS 13
`define DIP_TDM_BASE 64'h0000_0000_8000_0000
`define DIP_TDM_LAT_WIDE 2
`define DIP_TDM_LAT_NARROW 3
`define DIP_STORE_DEPTH 4
`endif

// ===== rtl/dip_pkg.sv
package dip_pkg;
  // ================================================================
  // instruction classes seen at the issue point
  typedef enum logic [3:0] {
    DIP_ALU = 4'h0,
    DIP_BRANCH = 4'h1,
    DIP_JUMP = 4'h2,
    DIP_LOAD = 4'h3,
    DIP_STORE = 4'h4,
    DIP_MUL = 4'h5,
    DIP_DIV = 4'h6,
    DIP_CSR_READ = 4'h7,
    DIP_CSR_WRITE = 4'h8,
    DIP_LRSC = 4'h9,
    DIP_NOP = 4'hF
  } dip_class_type;
  // ================================================================
  // issue control modes
  typedef enum logic [2:0] {
    DIP_RUN = 3'b001,
    DIP_FLUSH = 3'b010,
    DIP_PENALTY = 3'b100
  } dip_mode_type;
  // access size codes: byte, half, word, double
  typedef logic [1:0] dip_size_type;
endpackage : dip_pkg

// ===== rtl/dip_store_queue.sv
`timescale 1ns/100ps
`include "dip_params.svh"
module dip_store_queue
  import dip_pkg::*;
#(
  parameter int DEPTH = `DIP_STORE_DEPTH,
  parameter int AW = `DIP_TDM_ADDR_BITS
)(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pushValid,
  output logic pushReady,
  input wire logic [AW-1:0] pushAddr,
  input wire logic [63:0] pushData,
  input wire logic memIdle,
  output logic commitValid,
  output logic [AW-1:0] commitAddr,
  output logic [63:0] commitData,
  input wire logic [AW-1:0] probeAddr,
  output logic probeHit
);
  // ================================================================
  // elaboration check
  initial
  begin
    if (DEPTH < 1 || DEPTH > 15)
      $error("store queue depth out of range");
  end
  // ================================================================
  // state: entry array plus count, head at index zero
  typedef struct packed {
    logic [DEPTH-1:0][AW-1:0] addr; // queued addresses
    logic [DEPTH-1:0][63:0] data;   // queued store data
    logic [3:0] count;              // occupied entries
  } dip_sq_state_type;
  dip_sq_state_type state;
  dip_sq_state_type next_state;
  logic pop;
  logic push;
  // handshake outputs are combinational
  assign pushReady = (state.count < 4'(DEPTH));
  assign commitValid = memIdle && (state.count != 4'h0);
  assign commitAddr = state.addr[0];
  assign commitData = state.data[0];
  // ================================================================
  // a load compares against every pending entry
  always_comb
  begin
    probeHit = 1'b0;
    for (int i = 0; i < DEPTH; i++)
      if (4'(i) < state.count && state.addr[i] == probeAddr)
        probeHit = 1'b1;
  end
  // ================================================================
  // commit only when the memory is idle; shift queue on commit
  always_comb
  begin
    next_state = state;
    pop = commitValid;
    push = pushValid && pushReady;
    if (pop)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
      begin
        next_state.addr[i] = state.addr[i+1];
        next_state.data[i] = state.data[i+1];
      end
    end
    if (push)
    begin
      next_state.addr[state.count - 4'(pop)] = pushAddr;
      next_state.data[state.count - 4'(pop)] = pushData;
    end
    next_state.count = state.count + 4'(push) - 4'(pop);
  end
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      state <= '0;
    else
      state <= next_state;
  end
endmodule : dip_store_queue

// ===== test/dip_pipeline_monitor.sv
`timescale 1ns/100ps
module dip_pipeline_monitor
  import dip_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [1:0] issue,
  input wire dip_class_type [1:0] slotClass,
  input wire logic [1:0] slotCsrFlush,
  input wire logic [63:0] memAddr,
  input wire logic [63:0] memBase,
  input wire dip_size_type memSize,
  input wire logic divDone,
  input wire logic flush,
  input wire logic trapMisaligned,
  input wire logic trapAccess,
  input wire logic tdmReq,
  input wire logic tdmWrite,
  input wire logic loadDone,
  input wire logic ioRespValid,
  input wire logic ioLoadDone
);
  // ========================================
  // helpers
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  logic ld0, tight; // slot0 load taken; aligned tight word load
  assign ld0 = issue[0] && slotClass[0] == DIP_LOAD;
  assign tight = memAddr[63:13] == 51'h4_0000 && memAddr[1:0] == 2'h0
    && memBase[63:13] == memAddr[63:13] && memSize == 2'h2;
  // ========================================
  // checks
  chk_pair_order: assert property (issue[1] |-> issue[0])
    else $error("second slot issued alone");
  chk_csr_solo: assert property (issue[1] |-> !(slotClass[0] inside
    {DIP_CSR_READ, DIP_CSR_WRITE})) else $error("csr paired");
  chk_flush_gap: assert property (issue[0] && slotCsrFlush[0]
    && slotClass[0] == DIP_CSR_WRITE |=> flush ##0 (issue == 2'h0) [*6])
    else $error("csr flush gap wrong");
  chk_lrsc_trap: assert property (issue[0]
    && slotClass[0] == DIP_LRSC |=> trapAccess || trapMisaligned)
    else $error("no access trap");
  chk_misalign_trap: assert property (ld0 && memSize == 2'h2
    && memAddr[1:0] != 2'h0 |=> trapMisaligned && flush)
    else $error("misaligned load not trapped");
  chk_div_window: assert property (issue[0] && slotClass[0] == DIP_DIV
    |=> !divDone [*5] ##[1:63] divDone) else $error("divide latency");
  chk_tight_load: assert property (ld0 && tight
    |=> tdmReq && !tdmWrite ##1 loadDone) else $error("tight load timing");
  chk_io_echo: assert property (ioRespValid |=> ioLoadDone)
    else $error("io response lost");
  cover property (issue == 2'h3);
  cover property (divDone);
  cover property (ioLoadDone);
endmodule : dip_pipeline_monitor

bind dip_pipeline_ctrl dip_pipeline_monitor mon_u (.*);

// ===== test/dip_io_partner.sv
`timescale 1ns/100ps
module dip_io_partner (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic ioReq,
  output logic ioReady,
  output logic ioRespValid
);
  // ========================================
  // request age shifter; slow mode takes one at a time
  logic [3:0] age;
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      age <= 4'h0;
    else
      age <= {age[2:0], ioReq};
  assign ioReady = !(slow && |age);
  assign ioRespValid = slow ? age[3] : age[0];
endmodule : dip_io_partner

// ===== test/test_dual_issue_pipeline_timing.sv
`timescale 1ns/100ps
module test_dual_issue_pipeline_timing;
  import dip_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, slow = 1'b0, fetchValid = 1'b0;
  logic [1:0] slotValid = 2'h0, slotAddrRs1 = 2'h0, slotCsrFlush = 2'h0;
  dip_class_type [1:0] slotClass = '{default: DIP_NOP};
  logic [1:0][4:0] slotRd = {5'h2, 5'h1}, slotRs1 = 10'h0, slotRs2 = 10'h0;
  logic [63:0] memAddr = 64'h0, memBase = 64'h0, memData = 64'h0;
  logic [63:0] fetchAddr = 64'h0, tdmWdata, ioAddr;
  dip_size_type memSize = 2'h3;
  logic [6:0] divLogDividend = 7'h0, divLogDivisor = 7'h0;
  logic divNegIn = 1'b0, divNegOut = 1'b0, divDone, flush, icacheFill;
  logic trapMisaligned, trapAccess, tdmReq, tdmWrite, loadDone, ioReady;
  logic ioReq, ioWrite, ioRespValid, ioLoadDone;
  logic [1:0] issue, retireCount;
  logic [12:0] tdmAddr;
  logic [7:0] stageBusy;
  int n_errors = 0, total_checks = 0;
  dip_pipeline_ctrl dut_u (.*);
  dip_io_partner io_u (.*);
  // ========================================
  // clock, watchdog
  initial
  begin
    forever #20 core_clk = ~core_clk;
  end
  initial
  begin
    #400000;
    n_errors++;
    report_and_stop;
  end
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic mem(input logic [63:0] a, input dip_size_type s);
    memAddr <= a;
    memBase <= a;
    memSize <= s;
  endtask : mem
  // offer one cycle, judge the issue pattern
  task automatic go(input dip_class_type a, b, input logic [1:0] v, e,
    input logic [4:0] r);
    @(posedge core_clk);
    slotValid <= v;
    slotClass[0] <= a;
    slotClass[1] <= b;
    slotRs1 <= {r, 5'h0};
    slotCsrFlush <= {1'b0, a == DIP_CSR_WRITE};
    @(negedge core_clk);
    chk(issue === e, "issue pattern");
    @(posedge core_clk);
    slotValid <= 2'h0;
  endtask : go
  task automatic t_pairs;
    dip_class_type a[5] = '{DIP_ALU, DIP_LOAD, DIP_BRANCH, DIP_MUL,
      DIP_CSR_READ};
    dip_class_type b[5] = '{DIP_ALU, DIP_STORE, DIP_JUMP, DIP_DIV, DIP_ALU};
    mem(64'h8000_0040, 2'h3);
    for (int i = 0; i < 5; i++)
    begin
      go(a[i], b[i], 2'h3, i == 0 ? 2'h3 : 2'h1, 5'h0);
      repeat (4) @(negedge core_clk);
      chk(retireCount === (i == 0 ? 2'h2 : 2'h1), "retire count");
      repeat (4) @(posedge core_clk);
    end
    go(DIP_ALU, DIP_ALU, 2'h3, 2'h1, 5'h1);
    $display("pairs done");
  endtask : t_pairs
  task automatic t_csr;
    int n = 2;
    go(DIP_CSR_WRITE, DIP_NOP, 2'h1, 2'h1, 5'h0);
    @(negedge core_clk);
    chk(flush === 1'b1, "no flush");
    @(posedge core_clk);
    slotClass[0] <= DIP_ALU;
    slotCsrFlush <= 2'h0;
    slotValid <= 2'h1;
    @(negedge core_clk);
    while (issue[0] !== 1'b1 && n < 20)
    begin
      @(negedge core_clk);
      n++;
    end
    chk(n == 7, "flush gap");
    @(posedge core_clk);
    slotValid <= 2'h0;
    $display("csr done");
  endtask : t_csr
  task automatic t_div;
    int n;
    logic [6:0] d[3] = '{7'h0A, 7'h00, 7'h46};
    logic [6:0] s[3] = '{7'h02, 7'h03, 7'h00};
    int e[3] = '{11, 6, 68};
    for (int i = 0; i < 3; i++)
    begin
      divLogDividend <= d[i];
      divLogDivisor <= s[i];
      divNegIn <= i != 1;
      divNegOut <= i == 2;
      go(DIP_DIV, DIP_NOP, 2'h1, 2'h1, 5'h0);
      n = 1;
      if (i == 2)
      begin
        go(DIP_DIV, DIP_NOP, 2'h1, 2'h0, 5'h0);
        n = 3;
      end
      @(negedge core_clk);
      while (divDone !== 1'b1 && n < 80)
      begin
        @(negedge core_clk);
        n++;
      end
      chk(n == e[i], "divide latency");
    end
    $display("divide done");
  endtask : t_div
  task automatic t_mem;
    mem(64'h8000_0100, 2'h2);
    go(DIP_LOAD, DIP_NOP, 2'h1, 2'h1, 5'h0);
    @(negedge core_clk);
    chk(tdmReq === 1'b1 && tdmWrite === 1'b0, "tight request");
    @(negedge core_clk);
    chk(loadDone === 1'b1, "word load time");
    go(DIP_STORE, DIP_NOP, 2'h1, 2'h1, 5'h0);
    repeat (2) @(negedge core_clk);
    chk(tdmReq === 1'b1 && tdmWrite === 1'b1, "store commit");
    mem(64'h8000_0101, 2'h0);
    go(DIP_LOAD, DIP_NOP, 2'h1, 2'h1, 5'h0);
    repeat (2) @(negedge core_clk);
    chk(loadDone === 1'b0, "byte load early");
    @(negedge core_clk);
    chk(loadDone === 1'b1, "byte load time");
    mem(64'h8000_0102, 2'h2);
    go(DIP_LOAD, DIP_NOP, 2'h1, 2'h1, 5'h0);
    @(negedge core_clk);
    chk(trapMisaligned === 1'b1, "no misaligned trap");
    repeat (8) @(posedge core_clk);
    mem(64'h8000_0100, 2'h3);
    go(DIP_LRSC, DIP_NOP, 2'h1, 2'h1, 5'h0);
    @(negedge core_clk);
    chk(trapAccess === 1'b1, "no access trap");
    repeat (8) @(posedge core_clk);
    fetchAddr <= 64'h8000_0200;
    fetchValid <= 1'b1;
    @(posedge core_clk);
    fetchValid <= 1'b0;
    @(negedge core_clk);
    chk(icacheFill === 1'b1, "no line fill");
    $display("memory done");
  endtask : t_mem
  task automatic t_io(input logic s);
    int n = 1;
    repeat (4) @(posedge core_clk); // partner drains earlier requests
    slow <= s;
    mem(64'h1000_0000, 2'h3);
    go(DIP_LOAD, DIP_NOP, 2'h1, 2'h1, 5'h0);
    @(negedge core_clk);
    chk(ioReq === 1'b1 && ioWrite === 1'b0, "io request");
    while (ioLoadDone !== 1'b1 && n < 10)
    begin
      @(negedge core_clk);
      n++;
    end
    chk(n == (s ? 6 : 3), "io answer");
    $display("io done");
  endtask : t_io
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_pairs;
    t_csr;
    t_div;
    t_mem;
    t_io(1'b0);
    t_io(1'b1);
    report_and_stop;
  end
endmodule : test_dual_issue_pipeline_timing
